// ==== common/uesm_defs.vh ====
// register map, field positions, reset values and codes for the ep0 control
`ifndef UESM_DEFS_VH
`define UESM_DEFS_VH

// register indices; the byte address is four times the index
`define UESM_IDX_NAK_CTRL 16'hff62
`define UESM_IDX_NAK_MASK 16'hff63
`define UESM_IDX_SIE_DIRECT 16'hff64
`define UESM_IDX_STALL_CAUSE 16'hff70
`define UESM_ADDR_W 18

// endpoint_nak_control_reg fields
`define UESM_BIT_BULK_OUT_NAK 2
`define UESM_RST_NAK_CTRL 8'h00

// endpoint_nak_write_mask_reg fields
`define UESM_BIT_NAK_UNMASK 2
`define UESM_RST_NAK_MASK 8'h00

// serial_engine_direct_reg fields
`define UESM_BIT_FORCE_STALL 3
`define UESM_BIT_RESERVED_SDS 2
`define UESM_BIT_RESUME 0
`define UESM_RST_SIE_DIRECT 8'h00

// stall cause fields
`define UESM_BIT_CAUSE_WVALUE 0
`define UESM_BIT_CAUSE_OVERRUN 1
`define UESM_BIT_CAUSE_FW 2
`define UESM_RST_STALL_CAUSE 8'h00

// handshake codes towards the serial engine
`define UESM_HS_ACK 2'h0
`define UESM_HS_NAK 2'h1
`define UESM_HS_STALL 2'h2

// bus answers
`define UESM_RESP_OKAY 2'h0
`define UESM_RESP_SLVERR 2'h2

`endif

// ==== design/uesm_axil_port.v ====
// axi4-lite slave handshake engine: one write and one read in flight
`timescale 1ns/10ps
`include "uesm_defs.vh"

module uesm_axil_port (
  input wire clk_in,
  input wire rstn_in,
  input wire [`UESM_ADDR_W-1:0] awaddr_in,
  input wire awvalid_in,
  output reg awready_out,
  input wire [31:0] wdata_in,
  input wire [3:0] wstrb_in,
  input wire wvalid_in,
  output reg wready_out,
  output reg [1:0] bresp_out,
  output reg bvalid_out,
  input wire bready_in,
  input wire [`UESM_ADDR_W-1:0] araddr_in,
  input wire arvalid_in,
  output reg arready_out,
  output reg [31:0] rdata_out,
  output reg [1:0] rresp_out,
  output reg rvalid_out,
  input wire rready_in,
  output wire wr_stb_out,
  output reg [`UESM_ADDR_W-1:0] wr_addr_out,
  output reg [7:0] wr_data_out,
  output reg wr_lane_out,
  input wire wr_hit_in,
  output reg [`UESM_ADDR_W-1:0] rd_addr_out,
  input wire [7:0] rd_data_in,
  input wire rd_hit_in
);
  reg have_aw_q;
  reg have_w_q;
  reg have_ar_q;

  // both halves held and no answer pending
  assign wr_stb_out = have_aw_q & have_w_q & ~bvalid_out;

  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      have_aw_q <= 1'b0;
      have_w_q <= 1'b0;
      awready_out <= 1'b1;
      wready_out <= 1'b1;
      bvalid_out <= 1'b0;
      bresp_out <= `UESM_RESP_OKAY;
      wr_addr_out <= {`UESM_ADDR_W{1'b0}};
      wr_data_out <= 8'h00;
      wr_lane_out <= 1'b0;
    end else begin
      if (awvalid_in && awready_out) begin
        have_aw_q <= 1'b1;
        awready_out <= 1'b0;
        wr_addr_out <= awaddr_in;
      end
      if (wvalid_in && wready_out) begin
        have_w_q <= 1'b1;
        wready_out <= 1'b0;
        wr_data_out <= wdata_in[7:0];
        wr_lane_out <= wstrb_in[0];
      end
      if (wr_stb_out) begin
        have_aw_q <= 1'b0;
        have_w_q <= 1'b0;
        bvalid_out <= 1'b1;
        bresp_out <= wr_hit_in ? `UESM_RESP_OKAY : `UESM_RESP_SLVERR;
      end
      if (bvalid_out && bready_in) begin
        bvalid_out <= 1'b0;
        awready_out <= 1'b1;
        wready_out <= 1'b1;
      end
    end
  end

  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      have_ar_q <= 1'b0;
      arready_out <= 1'b1;
      rvalid_out <= 1'b0;
      rdata_out <= 32'h0000_0000;
      rresp_out <= `UESM_RESP_OKAY;
      rd_addr_out <= {`UESM_ADDR_W{1'b0}};
    end else begin
      if (arvalid_in && arready_out) begin
        have_ar_q <= 1'b1;
        arready_out <= 1'b0;
        rd_addr_out <= araddr_in;
      end
      if (have_ar_q && !rvalid_out) begin
        have_ar_q <= 1'b0;
        rvalid_out <= 1'b1;
        rdata_out <= {24'h00_0000, rd_data_in};
        rresp_out <= rd_hit_in ? `UESM_RESP_OKAY : `UESM_RESP_SLVERR;
      end
      if (rvalid_out && rready_in) begin
        rvalid_out <= 1'b0;
        arready_out <= 1'b1;
      end
    end
  end
endmodule

// ==== design/uesm_ep0_handshake.v ====
// endpoint 0 handshake choice, fixed when the engine asks for it
`timescale 1ns/10ps
`include "uesm_defs.vh"

module uesm_ep0_handshake (
  input wire clk_in,
  input wire rstn_in,
  input wire hs_req_in,
  input wire stall_in,
  input wire data_ready_in,
  output reg hs_valid_out,
  output reg [1:0] hs_code_out
);
  // the choice is taken from the stall bit as it stands at the request;
  // a stall set later only reaches the next transfer
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hs_valid_out <= 1'b0;
      hs_code_out <= `UESM_HS_NAK;
    end else begin
      hs_valid_out <= hs_req_in;
      if (hs_req_in) begin
        if (stall_in) begin
          hs_code_out <= `UESM_HS_STALL;
        end else if (!data_ready_in) begin
          hs_code_out <= `UESM_HS_NAK;
        end else begin
          hs_code_out <= `UESM_HS_ACK;
        end
      end
    end
  end
endmodule

// ==== design/uesm_top.v ====
// ep0 stall, resume drive and bulk out nak write-mask control with axi4-lite
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "uesm_defs.vh"

// How it works
// - a write to the bulk out nak bit lands only while the unmask bit is 1.
// - while the force-stall bit is 1 endpoint 0 answers with stall.
// - an unsupported wValue in set configuration or set interface sets it.
// - an ep0 overrun in an automatic request sets it, halt flag untouched.
// - the next setup token clears the force-stall bit.
// - software may set the force-stall bit only during a firmware request.
// - a stall set late may follow a nak and apply to the next transfer.
// - writes to the resume bit count only when remote wakeup is allowed.
// - resume signalling is driven for as long as the resume bit is 1.
// - the resume bit is sampled on the clock, so it needs a running clock.
// - writes to the bulk out nak bit are ignored while nak is being sent.
module uesm_top (
  input wire clk_in,
  input wire rstn_in,
  input wire [`UESM_ADDR_W-1:0] s_axi_awaddr_in,
  input wire [2:0] s_axi_awprot_in,
  input wire s_axi_awvalid_in,
  output wire s_axi_awready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  input wire s_axi_wvalid_in,
  output wire s_axi_wready_out,
  output wire [1:0] s_axi_bresp_out,
  output wire s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire [`UESM_ADDR_W-1:0] s_axi_araddr_in,
  input wire [2:0] s_axi_arprot_in,
  input wire s_axi_arvalid_in,
  output wire s_axi_arready_out,
  output wire [31:0] s_axi_rdata_out,
  output wire [1:0] s_axi_rresp_out,
  output wire s_axi_rvalid_out,
  input wire s_axi_rready_in,
  input wire remote_wakeup_allowed_in,
  input wire firmware_decoded_request_in,
  input wire setup_token_in,
  input wire unsupported_wvalue_in,
  input wire ep0_auto_overrun_in,
  input wire nak_sending_in,
  input wire bulk_out_nak_hw_set_in,
  input wire bulk_out_nak_hw_clr_in,
  input wire ep0_hs_req_in,
  input wire ep0_data_ready_in,
  output reg bulk_out_nak_control_out,
  output reg ep0_force_stall_out,
  output reg resume_signal_drive_out,
  output wire ep0_hs_valid_out,
  output wire [1:0] ep0_hs_code_out
);
  // ---------------------------------------------------------------
  // address map
  // ---------------------------------------------------------------
  localparam [`UESM_ADDR_W-1:0] ADDR_NAK_CTRL =
    {`UESM_IDX_NAK_CTRL, 2'b00};
  localparam [`UESM_ADDR_W-1:0] ADDR_NAK_MASK =
    {`UESM_IDX_NAK_MASK, 2'b00};
  localparam [`UESM_ADDR_W-1:0] ADDR_SIE_DIRECT =
    {`UESM_IDX_SIE_DIRECT, 2'b00};
  localparam [`UESM_ADDR_W-1:0] ADDR_STALL_CAUSE =
    {`UESM_IDX_STALL_CAUSE, 2'b00};

  // whole-register reset words, so each flop takes exactly its own bit
  localparam [7:0] RST_NAK_CTRL = `UESM_RST_NAK_CTRL;
  localparam [7:0] RST_SIE_DIRECT = `UESM_RST_SIE_DIRECT;
  localparam [7:0] RST_STALL_CAUSE = `UESM_RST_STALL_CAUSE;

  // ---------------------------------------------------------------
  // bus port
  // ---------------------------------------------------------------
  wire wr_stb;
  wire [`UESM_ADDR_W-1:0] wr_addr;
  wire [7:0] wr_data;
  wire wr_lane;
  wire [`UESM_ADDR_W-1:0] rd_addr;
  reg wr_hit;
  reg [7:0] rd_data;
  reg rd_hit;

  // protection bits carry no meaning for these registers
  uesm_axil_port u_port (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .awaddr_in(s_axi_awaddr_in),
    .awvalid_in(s_axi_awvalid_in),
    .awready_out(s_axi_awready_out),
    .wdata_in(s_axi_wdata_in),
    .wstrb_in(s_axi_wstrb_in),
    .wvalid_in(s_axi_wvalid_in),
    .wready_out(s_axi_wready_out),
    .bresp_out(s_axi_bresp_out),
    .bvalid_out(s_axi_bvalid_out),
    .bready_in(s_axi_bready_in),
    .araddr_in(s_axi_araddr_in),
    .arvalid_in(s_axi_arvalid_in),
    .arready_out(s_axi_arready_out),
    .rdata_out(s_axi_rdata_out),
    .rresp_out(s_axi_rresp_out),
    .rvalid_out(s_axi_rvalid_out),
    .rready_in(s_axi_rready_in),
    .wr_stb_out(wr_stb),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data),
    .wr_lane_out(wr_lane),
    .wr_hit_in(wr_hit),
    .rd_addr_out(rd_addr),
    .rd_data_in(rd_data),
    .rd_hit_in(rd_hit)
  );

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  reg wr_nak_ctrl;
  reg wr_nak_mask;
  reg wr_sie_direct;

  always @* begin
    wr_hit = 1'b0;
    wr_nak_ctrl = 1'b0;
    wr_nak_mask = 1'b0;
    wr_sie_direct = 1'b0;
    if (wr_addr == ADDR_NAK_CTRL) begin
      wr_hit = 1'b1;
      wr_nak_ctrl = wr_stb & wr_lane;
    end else if (wr_addr == ADDR_NAK_MASK) begin
      wr_hit = 1'b1;
      wr_nak_mask = wr_stb & wr_lane;
    end else if (wr_addr == ADDR_SIE_DIRECT) begin
      wr_hit = 1'b1;
      wr_sie_direct = wr_stb & wr_lane;
    end else if (wr_addr == ADDR_STALL_CAUSE) begin
      // read-only; the write is answered but has no effect
      wr_hit = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // nak write mask register
  // ---------------------------------------------------------------
  reg [7:0] nak_mask_q;

  // all bits are kept as written so a read shows exactly the last write;
  // only the unmask bit steers anything
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      nak_mask_q <= `UESM_RST_NAK_MASK;
    end else if (wr_nak_mask) begin
      nak_mask_q <= wr_data;
    end
  end

  wire bulk_out_nak_write_unmask;
  assign bulk_out_nak_write_unmask = nak_mask_q[`UESM_BIT_NAK_UNMASK];

  // ---------------------------------------------------------------
  // bulk out nak control bit
  // ---------------------------------------------------------------
  reg nak_write_ok;

  always @* begin
    nak_write_ok = wr_nak_ctrl & bulk_out_nak_write_unmask;
    if (nak_sending_in) begin
      nak_write_ok = 1'b0;
    end
  end

  // the fifo logic drives this bit as well; its events win over software
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bulk_out_nak_control_out <=
        RST_NAK_CTRL[`UESM_BIT_BULK_OUT_NAK];
    end else if (bulk_out_nak_hw_set_in) begin
      bulk_out_nak_control_out <= 1'b1;
    end else if (bulk_out_nak_hw_clr_in) begin
      bulk_out_nak_control_out <= 1'b0;
    end else if (nak_write_ok) begin
      bulk_out_nak_control_out <=
        wr_data[`UESM_BIT_BULK_OUT_NAK];
    end
  end

  // ---------------------------------------------------------------
  // force stall on endpoint 0
  // ---------------------------------------------------------------
  reg stall_hw_set;
  reg stall_fw_set;
  reg stall_fw_clr;

  always @* begin
    stall_hw_set = unsupported_wvalue_in | ep0_auto_overrun_in;
    stall_fw_set = 1'b0;
    stall_fw_clr = 1'b0;
    if (wr_sie_direct) begin
      if (wr_data[`UESM_BIT_FORCE_STALL]) begin
        stall_fw_set = firmware_decoded_request_in;
      end else begin
        stall_fw_clr = 1'b1;
      end
    end
  end

  // any set wins over a clear in the same cycle, so no stall cause is lost
  // to a setup token; the halt flag lives elsewhere and is never touched
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ep0_force_stall_out <=
        RST_SIE_DIRECT[`UESM_BIT_FORCE_STALL];
    end else if (stall_hw_set || stall_fw_set) begin
      ep0_force_stall_out <= 1'b1;
    end else if (setup_token_in || stall_fw_clr) begin
      ep0_force_stall_out <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // stall cause record
  // ---------------------------------------------------------------
  reg [2:0] stall_cause_q;
  wire [2:0] cause_set;

  assign cause_set[`UESM_BIT_CAUSE_WVALUE] = unsupported_wvalue_in;
  assign cause_set[`UESM_BIT_CAUSE_OVERRUN] = ep0_auto_overrun_in;
  assign cause_set[`UESM_BIT_CAUSE_FW] = stall_fw_set;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_cause
      always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          stall_cause_q[gi] <= RST_STALL_CAUSE[gi];
        end else if (cause_set[gi]) begin
          stall_cause_q[gi] <= 1'b1;
        end else if (setup_token_in) begin
          stall_cause_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // resume drive
  // ---------------------------------------------------------------
  // the bit is sampled on this clock; with the clock stopped the pin
  // stays frozen, so the wake-up logic must keep the clock alive
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      resume_signal_drive_out <=
        RST_SIE_DIRECT[`UESM_BIT_RESUME];
    end else if (wr_sie_direct && remote_wakeup_allowed_in) begin
      resume_signal_drive_out <= wr_data[`UESM_BIT_RESUME];
    end
  end

  // ---------------------------------------------------------------
  // reserved direct-control bit
  // ---------------------------------------------------------------
  reg sds_reserved_q;

  // kept only so a read returns what was written; it drives nothing
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sds_reserved_q <= 1'b0;
    end else if (wr_sie_direct) begin
      sds_reserved_q <= wr_data[`UESM_BIT_RESERVED_SDS];
    end
  end

  // ---------------------------------------------------------------
  // handshake towards the serial engine
  // ---------------------------------------------------------------
  uesm_ep0_handshake u_hs (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .hs_req_in(ep0_hs_req_in),
    .stall_in(ep0_force_stall_out),
    .data_ready_in(ep0_data_ready_in),
    .hs_valid_out(ep0_hs_valid_out),
    .hs_code_out(ep0_hs_code_out)
  );

  // ---------------------------------------------------------------
  // read decode
  // ---------------------------------------------------------------
  always @* begin
    rd_hit = 1'b0;
    rd_data = 8'h00;
    if (rd_addr == ADDR_NAK_CTRL) begin
      rd_hit = 1'b1;
      rd_data[`UESM_BIT_BULK_OUT_NAK] = bulk_out_nak_control_out;
    end else if (rd_addr == ADDR_NAK_MASK) begin
      rd_hit = 1'b1;
      rd_data = nak_mask_q;
    end else if (rd_addr == ADDR_SIE_DIRECT) begin
      rd_hit = 1'b1;
      rd_data[`UESM_BIT_FORCE_STALL] = ep0_force_stall_out;
      rd_data[`UESM_BIT_RESERVED_SDS] = sds_reserved_q;
      rd_data[`UESM_BIT_RESUME] = resume_signal_drive_out;
    end else if (rd_addr == ADDR_STALL_CAUSE) begin
      rd_hit = 1'b1;
      rd_data[2:0] = stall_cause_q;
    end
  end
endmodule

// ==== verif/testbench.sv ====
// self-checking bench for the ep0 stall, resume and nak mask control
`timescale 1ns/10ps
`include "uesm_defs.vh"

module testbench;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  localparam [17:0] A_NAK = `UESM_IDX_NAK_CTRL * 4;
  localparam [17:0] A_MSK = `UESM_IDX_NAK_MASK * 4;
  localparam [17:0] A_DIR = `UESM_IDX_SIE_DIRECT * 4;
  localparam [17:0] A_CAU = `UESM_IDX_STALL_CAUSE * 4;
  localparam [17:0] A_BAD = 18'h3fd94;
  localparam [1:0] OK = `UESM_RESP_OKAY;
  logic clk_in, rstn_in, s_axi_awvalid_in, s_axi_wvalid_in;
  logic s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in;
  logic [17:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in;
  logic remote_wakeup_allowed_in, firmware_decoded_request_in;
  logic unsupported_wvalue_in, ep0_auto_overrun_in, nak_sending_in;
  wire s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  wire s_axi_arready_out, s_axi_rvalid_out;
  wire [1:0] s_axi_bresp_out, s_axi_rresp_out, ep0_hs_code_out;
  wire [31:0] s_axi_rdata_out;
  wire setup_token_in, ep0_hs_req_in, ep0_data_ready_in, ep0_hs_valid_out;
  wire bulk_out_nak_control_out, ep0_force_stall_out;
  wire resume_signal_drive_out;
  int n_tests = 0;
  int n_mismatch = 0;

  // fifo events and protection bits are tied: no fifo logic in this bench
  uesm_top u_uesm_top (.clk_in, .rstn_in, .s_axi_awaddr_in,
    .s_axi_awprot_in(3'h0), .s_axi_awvalid_in, .s_axi_awready_out,
    .s_axi_wdata_in, .s_axi_wstrb_in(4'h1), .s_axi_wvalid_in,
    .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out,
    .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arprot_in(3'h0),
    .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
    .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in,
    .remote_wakeup_allowed_in, .firmware_decoded_request_in,
    .setup_token_in, .unsupported_wvalue_in, .ep0_auto_overrun_in,
    .nak_sending_in, .bulk_out_nak_hw_set_in(1'b0),
    .bulk_out_nak_hw_clr_in(1'b0), .ep0_hs_req_in, .ep0_data_ready_in,
    .bulk_out_nak_control_out, .ep0_force_stall_out,
    .resume_signal_drive_out, .ep0_hs_valid_out, .ep0_hs_code_out);

  uesm_host_model u_uesm_host_model (.clk_in,
    .ep0_hs_valid_in(ep0_hs_valid_out), .ep0_hs_code_in(ep0_hs_code_out),
    .setup_token_out(setup_token_in), .ep0_hs_req_out(ep0_hs_req_in),
    .ep0_data_ready_out(ep0_data_ready_in));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task check(input string what, input logic [31:0] got,
             input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task results();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one write; ends an edge after the answer so outputs have settled
  task wr(input logic [17:0] a, input logic [7:0] d, input logic [1:0] er);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= {24'h0, d};
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do begin
      @(posedge clk_in);
      if (s_axi_awready_out === 1'b1) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out === 1'b1) s_axi_wvalid_in <= 1'b0;
    end while (s_axi_bvalid_out !== 1'b1);
    s_axi_bready_in <= 1'b0;
    check("bresp", s_axi_bresp_out, er);
    @(posedge clk_in);
  endtask

  // ends an edge after the answer so a following read never re-drives
  // rready in the same time step
  task rd(input logic [17:0] a, input logic [7:0] exp, input string what);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do begin
      @(posedge clk_in);
      if (s_axi_arready_out === 1'b1) s_axi_arvalid_in <= 1'b0;
    end while (s_axi_rvalid_out !== 1'b1);
    s_axi_rready_in <= 1'b0;
    check(what, s_axi_rdata_out, {24'h0, exp});
    check({what, " resp"}, s_axi_rresp_out,
          a == A_BAD ? `UESM_RESP_SLVERR : OK);
    @(posedge clk_in);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_reset();
    rd(A_NAK, 8'h00, "nak reset");
    rd(A_MSK, 8'h00, "mask reset");
    rd(A_DIR, 8'h00, "direct reset");
    rd(A_CAU, 8'h00, "cause reset");
    check("stall reset", ep0_force_stall_out, 1'b0);
    $display("test reset done");
  endtask

  task t_nak_mask();
    wr(A_NAK, 8'h04, OK);
    check("nak masked", bulk_out_nak_control_out, 1'b0);
    wr(A_MSK, 8'h04, OK);
    rd(A_MSK, 8'h04, "mask readback");
    wr(A_NAK, 8'h04, OK);
    check("nak unmasked", bulk_out_nak_control_out, 1'b1);
    nak_sending_in <= 1'b1;
    wr(A_NAK, 8'h00, OK);
    check("nak while sending", bulk_out_nak_control_out, 1'b1);
    nak_sending_in <= 1'b0;
    wr(A_MSK, 8'h00, OK);
    wr(A_NAK, 8'h00, OK);
    check("nak masked again", bulk_out_nak_control_out, 1'b1);
    wr(A_BAD, 8'h04, `UESM_RESP_SLVERR);
    rd(A_BAD, 8'h00, "unmapped read");
    $display("test nak_mask done");
  endtask

  task t_stall();
    logic [1:0] c;
    wr(A_DIR, 8'h08, OK);
    check("stall outside fw", ep0_force_stall_out, 1'b0);
    u_uesm_host_model.transfer(0, 1'b1, c);
    check("ack code", c, `UESM_HS_ACK);
    firmware_decoded_request_in <= 1'b1;
    wr(A_DIR, 8'h08, OK);
    check("stall by fw", ep0_force_stall_out, 1'b1);
    rd(A_DIR, 8'h08, "direct readback");
    rd(A_CAU, 8'h04, "cause fw");
    u_uesm_host_model.transfer(3, 1'b0, c);
    check("stall code slow", c, `UESM_HS_STALL);
    firmware_decoded_request_in <= 1'b0;
    u_uesm_host_model.send_setup();
    check("stall cleared", ep0_force_stall_out, 1'b0);
    u_uesm_host_model.transfer(0, 1'b0, c);
    check("nak after setup", c, `UESM_HS_NAK);
    fork
      u_uesm_host_model.transfer(0, 1'b1, c);
      begin
        unsupported_wvalue_in <= 1'b1;
        @(posedge clk_in);
        unsupported_wvalue_in <= 1'b0;
      end
    join
    check("late stall first", c, `UESM_HS_ACK);
    u_uesm_host_model.transfer(0, 1'b1, c);
    check("late stall next", c, `UESM_HS_STALL);
    u_uesm_host_model.send_setup();
    ep0_auto_overrun_in <= 1'b1;
    @(posedge clk_in);
    ep0_auto_overrun_in <= 1'b0;
    @(posedge clk_in);
    check("overrun stall", ep0_force_stall_out, 1'b1);
    rd(A_CAU, 8'h02, "cause overrun");
    u_uesm_host_model.send_setup();
    check("overrun cleared", ep0_force_stall_out, 1'b0);
    $display("test stall done");
  endtask

  task t_resume();
    wr(A_DIR, 8'h01, OK);
    check("resume refused", resume_signal_drive_out, 1'b0);
    remote_wakeup_allowed_in <= 1'b1;
    wr(A_DIR, 8'h01, OK);
    repeat (30) @(posedge clk_in);
    check("resume held", resume_signal_drive_out, 1'b1);
    remote_wakeup_allowed_in <= 1'b0;
    wr(A_DIR, 8'h00, OK);
    check("resume clear refused", resume_signal_drive_out, 1'b1);
    remote_wakeup_allowed_in <= 1'b1;
    wr(A_DIR, 8'h00, OK);
    check("resume ended", resume_signal_drive_out, 1'b0);
    $display("test resume done");
  endtask

  // ---------------------------------------------------------------
  // clock, reset, sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  initial begin
    repeat (5000) @(posedge clk_in);
    n_mismatch++;
    results();
  end

  initial begin
    rstn_in = 1'b0;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 3'h0;
    {s_axi_arvalid_in, s_axi_rready_in} = 2'h0;
    s_axi_awaddr_in = 18'h0;
    s_axi_araddr_in = 18'h0;
    s_axi_wdata_in = 32'h0;
    remote_wakeup_allowed_in = 1'b0;
    firmware_decoded_request_in = 1'b0;
    unsupported_wvalue_in = 1'b0;
    ep0_auto_overrun_in = 1'b0;
    nak_sending_in = 1'b0;
    repeat (20) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    t_reset();
    t_nak_mask();
    t_stall();
    t_resume();
    results();
  end
endmodule

// ==== verif/uesm_checker_assertions.sv ====
// concurrent checks on the stall, resume and nak ports of uesm_top
`timescale 1ns/10ps
`include "uesm_defs.vh"

module uesm_checker (
  input wire clk_in,
  input wire rstn_in,
  input wire s_axi_bvalid_out,
  input wire setup_token_in,
  input wire unsupported_wvalue_in,
  input wire ep0_auto_overrun_in,
  input wire firmware_decoded_request_in,
  input wire remote_wakeup_allowed_in,
  input wire bulk_out_nak_hw_set_in,
  input wire bulk_out_nak_hw_clr_in,
  input wire ep0_hs_req_in,
  input wire ep0_hs_valid_out,
  input wire [1:0] ep0_hs_code_out,
  input wire bulk_out_nak_control_out,
  input wire ep0_force_stall_out,
  input wire resume_signal_drive_out
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  wire hw_stall = unsupported_wvalue_in || ep0_auto_overrun_in;

  AST_STALL_HS: assert property (ep0_hs_req_in && ep0_force_stall_out |=>
    ep0_hs_valid_out && ep0_hs_code_out == `UESM_HS_STALL)
    else $error("stalled endpoint 0 not answered with stall");
  AST_NO_STALL_HS: assert property (ep0_hs_req_in && !ep0_force_stall_out
    |=> ep0_hs_code_out != `UESM_HS_STALL)
    else $error("stall answered while bit clear");
  AST_HS_CAUSE: assert property (ep0_hs_valid_out |-> $past(ep0_hs_req_in))
    else $error("handshake without request");
  AST_HW_SET: assert property (hw_stall |=> ep0_force_stall_out)
    else $error("hardware stall cause did not set stall");
  AST_SETUP_CLR: assert property (setup_token_in && !hw_stall &&
    !firmware_decoded_request_in |=> !ep0_force_stall_out)
    else $error("setup token did not clear stall");
  AST_STALL_SRC: assert property ($rose(ep0_force_stall_out) |->
    $past(hw_stall || firmware_decoded_request_in))
    else $error("stall set outside firmware request");
  AST_RESUME_SRC: assert property ($changed(resume_signal_drive_out) |->
    $rose(s_axi_bvalid_out) && $past(remote_wakeup_allowed_in))
    else $error("resume changed without allowed write");
  AST_RESUME_HOLD: assert property (resume_signal_drive_out |=>
    resume_signal_drive_out || $rose(s_axi_bvalid_out))
    else $error("resume dropped on its own");
  AST_NAK_SRC: assert property ($changed(bulk_out_nak_control_out) |->
    $rose(s_axi_bvalid_out) ||
    $past(bulk_out_nak_hw_set_in || bulk_out_nak_hw_clr_in))
    else $error("nak bit changed without cause");
endmodule

bind uesm_top uesm_checker u_uesm_checker (.clk_in, .rstn_in,
  .s_axi_bvalid_out, .setup_token_in, .unsupported_wvalue_in,
  .ep0_auto_overrun_in, .firmware_decoded_request_in,
  .remote_wakeup_allowed_in, .bulk_out_nak_hw_set_in,
  .bulk_out_nak_hw_clr_in, .ep0_hs_req_in, .ep0_hs_valid_out,
  .ep0_hs_code_out, .bulk_out_nak_control_out, .ep0_force_stall_out,
  .resume_signal_drive_out);

// ==== verif/uesm_host_model.sv ====
// behavioural usb host side: setup tokens and endpoint 0 transfers
`timescale 1ns/10ps

module uesm_host_model (
  input wire clk_in,
  input wire ep0_hs_valid_in,
  input wire [1:0] ep0_hs_code_in,
  output logic setup_token_out,
  output logic ep0_hs_req_out,
  output logic ep0_data_ready_out
);
  initial begin
    setup_token_out = 1'b0;
    ep0_hs_req_out = 1'b0;
    ep0_data_ready_out = 1'b0;
  end

  // a new control transfer always opens with a setup token
  task send_setup();
    setup_token_out <= 1'b1;
    @(posedge clk_in);
    setup_token_out <= 1'b0;
    @(posedge clk_in);
  endtask

  // gap idle cycles make the host prompt or slow; 3 marks no answer
  task transfer(input int gap, input logic rdy, output logic [1:0] code);
    int n;
    repeat (gap) @(posedge clk_in);
    ep0_data_ready_out <= rdy;
    ep0_hs_req_out <= 1'b1;
    @(posedge clk_in);
    ep0_hs_req_out <= 1'b0;
    code = 2'h3;
    for (n = 0; n < 8 && code === 2'h3; n++) begin
      @(posedge clk_in);
      if (ep0_hs_valid_in === 1'b1) code = ep0_hs_code_in;
    end
  endtask
endmodule
